/* File: bench/papd_chk_sva.sv */
`timescale 1ns/1ns
// Pin-level watcher for the power control block
module papd_chk (
	input logic        pclk,
	input logic        presetn,
	input logic [7:0]  paddr,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [31:0] pwdata,
	input logic [7:0]  fdc_msr,
	input logic        fdc_int,
	input logic        fdc_head_unloaded,
	input logic [7:0]  fdc_data_wr,
	input logic        fdc_data_wr_stb,
	input logic        fdc_soft_reset,
	input logic        fdc_pd,
	input logic        core_step_n,
	input logic        core_dir_n,
	input logic        core_hdsel_n,
	input logic [1:0]  core_den,
	input logic [1:0]  motor_on_out_n,
	input logic        motor_on_oe,
	input logic        write_gate_oe,
	input logic        step_pulse_out_n,
	input logic        step_direction_out_n,
	input logic        head_select_out_n,
	input logic [1:0]  drive_density_out,
	input logic [1:0]  serial_receive_input,
	input logic [1:0]  ring_indicator_input,
	input logic [1:0]  transmit_holding_buffer_wr,
	input logic [1:0]  uart_tx_pd,
	input logic [1:0]  uart_rx_pd,
	input logic [1:0]  uart_ri_change
);
	logic acc;
	// Access phase of any bus transfer
	assign acc = psel && penable;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	oe_track_a: assert property (motor_on_oe == !fdc_pd && write_gate_oe == !fdc_pd)
		else $error("drive enables do not track powerdown");
	step_live_a: assert property ($past(presetn) |-> step_pulse_out_n == $past(core_step_n))
		else $error("step pin stopped following core");
	// The other always-driven pins must keep following the core in powerdown
	pins_live_a: assert property ($past(presetn) |->
		{step_direction_out_n, head_select_out_n, drive_density_out}
		== $past({core_dir_n, core_hdsel_n, core_den}))
		else $error("direction, head or density pin stopped following core");
	// Rises within two cycles of any write excluded: only auto entry needs an idle core
	sleep_cause_a: assert property (
		$rose(fdc_pd) && !$past(acc && pwrite) && !$past(acc && pwrite, 2) |->
		$past(fdc_msr == 8'h80 && !fdc_int && fdc_head_unloaded && motor_on_out_n == 2'b11))
		else $error("powerdown entered with core not idle");
	access_wake_a: assert property (
		acc && (paddr == 8'h14 || paddr == 8'h10 && !pwrite) |-> ##[1:2] !fdc_pd)
		else $error("status or data access did not wake");
	motor_wake_a: assert property (
		acc && pwrite && paddr == 8'h08 && pwdata[5:4] != 2'b00 |->
		##[1:2] (!fdc_pd && motor_on_out_n != 2'b11))
		else $error("motor write did not wake");
	asleep_kept_a: assert property (
		fdc_pd && acc && (paddr == 8'h00 || paddr == 8'h1c ||
		paddr == 8'h08 && (!pwrite || pwdata[5:2] == 4'h1)) |=> fdc_pd [*2])
		else $error("non-waking access left powerdown");
	data_kept_a: assert property (
		acc && pwrite && paddr == 8'h14 |=> fdc_data_wr_stb && fdc_data_wr == $past(pwdata[7:0]))
		else $error("data port write lost");
	soft_reset_a: assert property (
		acc && pwrite && paddr == 8'h10 && pwdata[7] |=> fdc_soft_reset)
		else $error("rate reset bit gave no reset");
	tx_wake_a: assert property (transmit_holding_buffer_wr[1] |=> !uart_tx_pd[1])
		else $error("transmit write did not wake");
	rx_wake_a: assert property (
		uart_rx_pd[0] && $changed(serial_receive_input[0]) |=> !uart_rx_pd[0])
		else $error("receive edge did not wake");
	ring_pass_a: assert property ($changed(ring_indicator_input[1]) |=> uart_ri_change[1])
		else $error("ring change not reported");
	cover property (acc && !pwrite && paddr == 8'h10 && fdc_pd);
	cover property ($rose(fdc_pd));
	cover property (uart_rx_pd[0] && $changed(serial_receive_input[0]));
endmodule

/* File: bench/papd_drive_model.sv */
`timescale 1ns/1ns
// Floppy core and serial line stub on the far side of the block
module papd_drive_model (
	input  logic       pclk,
	input  logic       core_busy,
	input  logic [1:0] transmit_holding_buffer_wr,
	output logic [7:0] fdc_msr,
	output logic       fdc_int,
	output logic       fdc_head_unloaded,
	output logic [7:0] fdc_sta,
	output logic [7:0] fdc_stb,
	output logic [7:0] fdc_din,
	output logic [7:0] fdc_data_rd,
	output logic       core_wdata_n,
	output logic       core_wgate_n,
	output logic       core_dir_n,
	output logic       core_step_n,
	output logic       core_hdsel_n,
	output logic [1:0] core_den,
	output logic [1:0] uart_thr_empty,
	output logic [1:0] uart_tsr_empty,
	output logic [1:0] uart_rx_fifo_empty,
	output logic [1:0] uart_rx_idle
);
	logic [7:0] cnt_r = 8'h00;
	logic [7:0] tx_busy_r = 8'h00;
	// Pattern keeps every drive pin moving; a write keeps the shifter busy
	always @(posedge pclk) begin
		cnt_r <= cnt_r + 8'h01;
		tx_busy_r <= {tx_busy_r[6:0], |transmit_holding_buffer_wr};
	end
	// A busy core shows a command phase, a loaded head and polling interrupts
	assign fdc_msr = core_busy ? 8'h90 : 8'h80;
	assign fdc_int = core_busy & cnt_r[3];
	assign fdc_head_unloaded = !core_busy;
	assign fdc_sta = cnt_r;
	assign fdc_stb = ~cnt_r;
	assign fdc_din = {cnt_r[3:0], 4'h0};
	assign fdc_data_rd = cnt_r ^ 8'h3c;
	assign {core_den, core_hdsel_n, core_dir_n, core_wgate_n, core_wdata_n, core_step_n} = cnt_r[6:0];
	assign uart_thr_empty = {2{tx_busy_r == 8'h00}};
	assign uart_tsr_empty = {2{tx_busy_r == 8'h00}};
	assign uart_rx_fifo_empty = 2'b11;
	assign uart_rx_idle = 2'b11;
endmodule

/* File: bench/papd_top_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("FAIL %s expected %0h seen %0h", n, e, g); \
	end \
end
module papd_top_tb;
	localparam int IC = 20;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, core_busy;
	logic        fdc_int, fdc_head_unloaded, fdc_data_wr_stb, fdc_data_rd_stb, fdc_soft_reset;
	logic        fdc_pd, core_wdata_n, core_wgate_n, core_dir_n, core_step_n, core_hdsel_n;
	logic        motor_on_oe, drive_select_oe, write_data_out_n, write_data_oe, write_gate_out_n;
	logic        write_gate_oe, step_direction_out_n, step_pulse_out_n, head_select_out_n;
	logic        epp_pd, ecp_pd;
	logic [1:0]  core_den, motor_on_out_n, drive_select_out_n, drive_density_out;
	logic [1:0]  uart_thr_empty, uart_tsr_empty, uart_rx_fifo_empty, uart_rx_idle;
	logic [1:0]  serial_receive_input, ring_indicator_input, transmit_holding_buffer_wr;
	logic [1:0]  uart_tx_pd, uart_rx_pd, uart_ri_change;
	logic [2:0]  ecr_mode;
	logic [7:0]  paddr, fdc_msr, fdc_sta, fdc_stb, fdc_din, fdc_data_rd, fdc_data_wr;
	logic [7:0]  fdc_rate, fdc_ccr;
	logic [31:0] pwdata, prdata, rd;
	int          bad_count, check_count;
	papd_top #(.IDLE_CYCLES(IC)) uut (.*);
	papd_drive_model u_drv (.*);
	////////////////////////////////////////////////////////////////////////
	// One bus transfer; holds everything until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Checks land mid-cycle so no edge race decides them
	task automatic wait_n(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Run is under a thousand cycles; this bound is far beyond it
	initial begin
		#2_000_000;
		bad_count++;
		end_of_test();
	end
	initial begin
		{presetn, psel, penable, pwrite, core_busy} = 5'h00;
		{paddr, pwdata, ecr_mode} = 43'h0;
		// Serial lines idle high, as the receiver's edge detector expects
		{serial_receive_input, ring_indicator_input, transmit_holding_buffer_wr} = 6'h30;
		bad_count = 0;
		check_count = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, 8'h08, 32'h0);
		`CHK("doc", 32'h04, rd)
		xfer(1'b0, 8'h30, 32'h0);
		`CHK("unmapped err", 1'b1, er)
		`CHK("unmapped data", 32'h0, rd)
		wait_n(IC + 5);
		`CHK("pd disabled", 1'b0, fdc_pd)
		`CHK("tx disabled", 2'b00, uart_tx_pd)
		xfer(1'b1, 8'h24, 32'h01);
		wait_n(IC - 5);
		`CHK("pd early", 1'b0, fdc_pd)
		wait_n(12);
		`CHK("pd auto", 1'b1, fdc_pd)
		`CHK("motor oe", 1'b0, motor_on_oe)
		`CHK("dsel oe", 1'b0, drive_select_oe)
		`CHK("wdata oe", 1'b0, write_data_oe)
		xfer(1'b0, 8'h28, 32'h0);
		`CHK("power status", 32'h03, rd)
		xfer(1'b1, 8'h08, 32'h04);
		xfer(1'b1, 8'h1c, 32'h01);
		wait_n(2);
		`CHK("pd kept", 1'b1, fdc_pd)
		xfer(1'b0, 8'h10, 32'h0);
		`CHK("main status", 32'h80, rd)
		wait_n(2);
		`CHK("pd status wake", 1'b0, fdc_pd)
		`CHK("ccr kept", 8'h01, fdc_ccr)
		wait_n(IC - 8);
		`CHK("pd restart", 1'b0, fdc_pd)
		wait_n(14);
		`CHK("pd again", 1'b1, fdc_pd)
		@(posedge pclk) core_busy <= 1'b1;
		xfer(1'b1, 8'h08, 32'h14);
		wait_n(2);
		`CHK("pd motor wake", 1'b0, fdc_pd)
		`CHK("motor pins", 2'b10, motor_on_out_n)
		wait_n(80);
		xfer(1'b1, 8'h14, 32'h5a);
		wait_n(2);
		`CHK("data out", 8'h5a, fdc_data_wr)
		xfer(1'b1, 8'h08, 32'h04);
		wait_n(IC + 5);
		`CHK("pd busy", 1'b0, fdc_pd)
		@(posedge pclk) core_busy <= 1'b0;
		wait_n(4);
		`CHK("pd last cond", 1'b1, fdc_pd)
		xfer(1'b1, 8'h10, 32'h42);
		xfer(1'b1, 8'h24, 32'h00);
		wait_n(2);
		`CHK("pd rate held", 1'b1, fdc_pd)
		xfer(1'b1, 8'h10, 32'h02);
		wait_n(2);
		`CHK("pd auto off", 1'b0, fdc_pd)
		xfer(1'b1, 8'h24, 32'h01);
		wait_n(IC + 8);
		`CHK("pd auto back", 1'b1, fdc_pd)
		xfer(1'b1, 8'h10, 32'h82);
		wait_n(2);
		`CHK("pd soft reset", 1'b0, fdc_pd)
		`CHK("rate", 8'h02, fdc_rate)
		xfer(1'b1, 8'h20, 32'h01);
		wait_n(2);
		`CHK("pd direct", 1'b1, fdc_pd)
		xfer(1'b1, 8'h20, 32'h00);
		wait_n(80);
		xfer(1'b1, 8'h24, 32'h30);
		wait_n(3);
		`CHK("tx pd", 2'b11, uart_tx_pd)
		`CHK("rx pd", 2'b11, uart_rx_pd)
		@(posedge pclk) transmit_holding_buffer_wr <= 2'b10;
		@(posedge pclk) transmit_holding_buffer_wr <= 2'b00;
		wait_n(2);
		`CHK("tx wake", 2'b01, uart_tx_pd)
		@(posedge pclk) serial_receive_input <= 2'b10;
		wait_n(2);
		`CHK("rx wake", 2'b10, uart_rx_pd)
		@(posedge pclk) ring_indicator_input <= 2'b10;
		wait_n(1);
		`CHK("ring", 2'b10, uart_ri_change)
		xfer(1'b1, 8'h2c, 32'h03);
		xfer(1'b1, 8'h24, 32'h08);
		for (int m = 0; m < 8; m++) begin
			@(posedge pclk) ecr_mode <= m[2:0];
			wait_n(3);
			`CHK("epp pd", (m != 4), epp_pd)
			`CHK("ecp pd", (m == 0 || m == 1 || m == 4), ecp_pd)
		end
		xfer(1'b1, 8'h2c, 32'h00);
		wait_n(3);
		`CHK("pp off", 2'b11, {epp_pd, ecp_pd})
		xfer(1'b1, 8'h24, 32'h00);
		wait_n(3);
		`CHK("pp auto off", 2'b00, {epp_pd, ecp_pd})
		// Hardware reset in mid-run must wake from auto powerdown and clear config
		xfer(1'b1, 8'h24, 32'h01);
		wait_n(IC + 5);
		`CHK("pd before reset", 1'b1, fdc_pd)
		@(posedge pclk) presetn <= 1'b0;
		wait_n(1);
		`CHK("pd hw reset", 1'b0, fdc_pd)
		`CHK("rate hw reset", 8'h02, fdc_rate)
		@(posedge pclk) presetn <= 1'b1;
		xfer(1'b0, 8'h24, 32'h0);
		`CHK("auto cfg hw reset", 32'h0, rd)
		end_of_test();
	end
endmodule
bind papd_top papd_chk u_chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
	.fdc_msr, .fdc_int, .fdc_head_unloaded, .fdc_data_wr, .fdc_data_wr_stb, .fdc_soft_reset,
	.fdc_pd, .core_step_n, .motor_on_out_n, .motor_on_oe, .write_gate_oe, .step_pulse_out_n,
	.core_dir_n, .core_hdsel_n, .core_den, .step_direction_out_n, .head_select_out_n,
	.drive_density_out,
	.serial_receive_input, .ring_indicator_input, .transmit_holding_buffer_wr, .uart_tx_pd,
	.uart_rx_pd, .uart_ri_change);

/* File: hw/papd_idle_timer.sv */
`timescale 1ns/1ns
module papd_idle_timer #(
	parameter int unsigned TC = papd_pkg::IDLE_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clear,
	output logic      done
);
	typedef struct packed {
		logic [papd_pkg::CNT_W-1:0] cnt;
		logic                       done;
	} papd_tmr_st_t;
	papd_tmr_st_t r;
	papd_tmr_st_t n;

	// Counts bus clocks; any wake clears and restarts it
	always_comb begin
		n = r;
		if (clear) begin
			n.cnt  = '0;
			n.done = 1'b0;
		end else if (!r.done) begin
			n.cnt  = r.cnt + 1'b1;
			n.done = (r.cnt == papd_pkg::CNT_W'(TC - 1));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			r <= '0;
		else
			r <= n;
	end

	assign done = r.done;
endmodule

/* File: hw/papd_pkg.sv */
// Functional notes
// - Each unit has a direct powerdown bit, separate from auto powerdown.
// - Floppy auto powerdown allowed only while auto config bit 0 is set.
// - Floppy sleeps only: motors off, status 80h, no interrupt, head unloaded, idle timer done.
// - Idle timer starts when auto enabled; sleep when last condition met.
// - Clearing the auto enable cancels the timer and keeps the floppy awake.
// - Rate-select powerdown overrides auto powerdown; auto governs again after it.
// - Hardware or software reset wake runs the full reset sequence.
// - Drive control write with a motor bit wakes; reads and other writes do not.
// - Main status read or data port access wakes with no state lost.
// - Every wake restarts the 10 ms idle timer; sleep again when conditions hold.
// - Non-waking accesses in powerdown read true status, keep writes, stay asleep.
// - Host bus, reset, clock and interrupt pins unaffected by powerdown.
// - Motor, select, write data, write gate tristate; step, head, density stay active.
// - UART auto powerdown allowed only by auto config bits 4 and 5.
// - Transmitter sleeps with buffer and shifter empty, wakes on buffer write.
// - Receiver sleeps only with empty FIFO while idle awaiting start bit.
// - Receiver wakes on any receive input change; ring change still reported.
// - Parallel port auto powerdown allowed only while auto config bit 3 set.
// - EPP logic off when EPP disabled or ECP mode selects other than EPP.
// - ECP logic off when disabled or SPP/PS2/EPP selected; re-evaluated on changes.
package papd_pkg;
	localparam int unsigned CLK_HZ   = 10_000_000;
	localparam int unsigned IDLE_MS  = 10;
	localparam int unsigned IDLE_CYC = CLK_HZ / 1000 * IDLE_MS;
	localparam int unsigned CNT_W    = 17;
	// Register indices, byte address is four times the index
	localparam logic [3:0] IDX_STA  = 4'h0;
	localparam logic [3:0] IDX_STB  = 4'h1;
	localparam logic [3:0] IDX_DOC  = 4'h2;
	localparam logic [3:0] IDX_RATE = 4'h4;
	localparam logic [3:0] IDX_DATA = 4'h5;
	localparam logic [3:0] IDX_DIN  = 4'h7;
	localparam logic [3:0] IDX_DPD  = 4'h8;
	localparam logic [3:0] IDX_APD  = 4'h9;
	localparam logic [3:0] IDX_PST  = 4'ha;
	localparam logic [3:0] IDX_PPC  = 4'hb;
	// Field positions
	localparam int unsigned DOC_MTR   = 4;
	localparam int unsigned DOC_RSTN  = 2;
	localparam int unsigned DSR_SWRST = 7;
	localparam int unsigned DSR_PD    = 6;
	localparam int unsigned CFG_FD    = 0;
	localparam int unsigned CFG_PP    = 3;
	localparam int unsigned CFG_U0    = 4;
	localparam logic [7:0]  MSR_IDLE  = 8'h80;
	localparam logic [2:0]  ECR_SPP   = 3'h0;
	localparam logic [2:0]  ECR_PS2   = 3'h1;
	localparam logic [2:0]  ECR_EPP   = 3'h4;
	// Values after reset
	localparam logic [7:0] DOC_RST = 8'h04;
	localparam logic [7:0] DSR_RST = 8'h02;
	localparam logic [7:0] CCR_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	typedef enum logic [1:0] {FD_RUN, FD_AUTO_PD, FD_RATE_PD} papd_fd_state_t;
endpackage

/* File: hw/papd_top.sv */
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
module papd_top #(
	parameter int unsigned IDLE_CYCLES = papd_pkg::IDLE_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  fdc_msr,
	input  wire logic        fdc_int,
	input  wire logic        fdc_head_unloaded,
	input  wire logic [7:0]  fdc_sta,
	input  wire logic [7:0]  fdc_stb,
	input  wire logic [7:0]  fdc_din,
	input  wire logic [7:0]  fdc_data_rd,
	output logic      [7:0]  fdc_data_wr,
	output logic             fdc_data_wr_stb,
	output logic             fdc_data_rd_stb,
	output logic             fdc_soft_reset,
	output logic      [7:0]  fdc_rate,
	output logic      [7:0]  fdc_ccr,
	output logic             fdc_pd,
	input  wire logic        core_wdata_n,
	input  wire logic        core_wgate_n,
	input  wire logic        core_dir_n,
	input  wire logic        core_step_n,
	input  wire logic        core_hdsel_n,
	input  wire logic [1:0]  core_den,
	output logic      [1:0]  motor_on_out_n,
	output logic             motor_on_oe,
	output logic      [1:0]  drive_select_out_n,
	output logic             drive_select_oe,
	output logic             write_data_out_n,
	output logic             write_data_oe,
	output logic             write_gate_out_n,
	output logic             write_gate_oe,
	output logic             step_direction_out_n,
	output logic             step_pulse_out_n,
	output logic             head_select_out_n,
	output logic      [1:0]  drive_density_out,
	input  wire logic [1:0]  uart_thr_empty,
	input  wire logic [1:0]  uart_tsr_empty,
	input  wire logic [1:0]  uart_rx_fifo_empty,
	input  wire logic [1:0]  uart_rx_idle,
	input  wire logic [1:0]  serial_receive_input,
	input  wire logic [1:0]  ring_indicator_input,
	input  wire logic [1:0]  transmit_holding_buffer_wr,
	output logic      [1:0]  uart_tx_pd,
	output logic      [1:0]  uart_rx_pd,
	output logic      [1:0]  uart_ri_change,
	input  wire logic [2:0]  ecr_mode,
	output logic             epp_pd,
	output logic             ecp_pd
);
	typedef struct packed {
		papd_pkg::papd_fd_state_t st;
		logic [7:0]  doc;
		logic [7:0]  dsr;
		logic [7:0]  rate_control_write;
		logic [7:0]  dpd;
		logic [7:0]  apd;
		logic [1:0]  ppc;
		logic [31:0] rdata;
		logic [7:0]  wdata;
		logic        wr_stb;
		logic        rd_stb;
		logic        sw_rst;
		logic        pd;
		logic [1:0]  mtr_n;
		logic [1:0]  ds_n;
		logic        wd_n;
		logic        wg_n;
		logic        dir_n;
		logic        step_n;
		logic        hd_n;
		logic [1:0]  den;
		logic        epp_pd;
		logic        ecp_pd;
	} papd_top_st_t;
	papd_top_st_t r;
	papd_top_st_t n;

	logic       acc;
	logic       wr;
	logic       rd;
	logic [3:0] idx;
	logic       mapped;
	logic       motor_wake;
	logic       sw_rst;
	logic       wake;
	logic       tmr_clear;
	logic       tmr_done;
	logic       fd_auto_en;
	logic       fd_idle;
	logic [1:0] u_tx_pd;
	logic [1:0] u_rx_pd;
	logic [1:0] u_ri_chg;

	////////////////////////////////////////////////////////////////////////////
	// APB decode

	// Word aligned index; anything outside the map answers with an error
	always_comb begin
		idx = paddr[5:2];
		case (paddr[5:2])
			papd_pkg::IDX_STA,
			papd_pkg::IDX_STB,
			papd_pkg::IDX_DOC,
			papd_pkg::IDX_RATE,
			papd_pkg::IDX_DATA,
			papd_pkg::IDX_DIN,
			papd_pkg::IDX_DPD,
			papd_pkg::IDX_APD,
			papd_pkg::IDX_PST,
			papd_pkg::IDX_PPC: mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
			default:           mapped = 1'b0;
		endcase
	end

	// Zero wait states; the bus is never gated by powerdown
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign acc     = psel && penable && mapped;
	assign wr      = acc && pwrite;
	assign rd      = acc && !pwrite;

	////////////////////////////////////////////////////////////////////////////
	// Wake sources

	// Only motor bits or reset bits in the drive control write wake the part
	assign motor_wake = wr && (idx == papd_pkg::IDX_DOC)
		&& (pwdata[papd_pkg::DOC_MTR+1:papd_pkg::DOC_MTR] != 2'h0);
	assign sw_rst = wr && (((idx == papd_pkg::IDX_DOC) && !pwdata[papd_pkg::DOC_RSTN])
		|| ((idx == papd_pkg::IDX_RATE) && pwdata[papd_pkg::DSR_SWRST]));
	assign wake = motor_wake || sw_rst
		|| (rd && (idx == papd_pkg::IDX_RATE))
		|| (acc && (idx == papd_pkg::IDX_DATA));

	// Timer runs only while enabled, and restarts on every wake
	assign fd_auto_en = r.apd[papd_pkg::CFG_FD];
	assign tmr_clear  = !fd_auto_en || wake;

	// All sleep conditions at once; the last one met triggers entry
	assign fd_idle = fd_auto_en
		&& (r.doc[papd_pkg::DOC_MTR+1:papd_pkg::DOC_MTR] == 2'h0)
		&& (fdc_msr == papd_pkg::MSR_IDLE) && !fdc_int
		&& fdc_head_unloaded && tmr_done;

	papd_idle_timer #(
		.TC (IDLE_CYCLES)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (tmr_clear),
		.done    (tmr_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// UART powerdown

	papd_uart_if u_if[2] ();

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_uart
			assign u_if[gi].thr_empty     = uart_thr_empty[gi];
			assign u_if[gi].tsr_empty     = uart_tsr_empty[gi];
			assign u_if[gi].rx_fifo_empty = uart_rx_fifo_empty[gi];
			assign u_if[gi].rx_idle       = uart_rx_idle[gi];
			assign u_if[gi].rxd           = serial_receive_input[gi];
			assign u_if[gi].ri            = ring_indicator_input[gi];
			assign u_if[gi].thb_wr        = transmit_holding_buffer_wr[gi];
			assign u_if[gi].auto_en       = r.apd[papd_pkg::CFG_U0 + gi];
			assign u_if[gi].direct_pd     = r.dpd[papd_pkg::CFG_U0 + gi];
			assign u_tx_pd[gi]            = u_if[gi].tx_pd;
			assign u_rx_pd[gi]            = u_if[gi].rx_pd;
			assign u_ri_chg[gi]           = u_if[gi].ri_change;
			papd_uart_pd u_pd (
				.pclk    (pclk),
				.presetn (presetn),
				.u       (u_if[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		n        = r;
		n.wr_stb = 1'b0;
		n.rd_stb = 1'b0;

		// Writes land whether asleep or not and take effect on wake
		if (wr) begin
			case (idx)
				papd_pkg::IDX_DOC:  n.doc = pwdata[7:0];
				papd_pkg::IDX_RATE: n.dsr = pwdata[7:0] & 8'h7f;
				papd_pkg::IDX_DIN:  n.rate_control_write = pwdata[7:0];
				papd_pkg::IDX_DPD:  n.dpd = pwdata[7:0];
				papd_pkg::IDX_APD:  n.apd = pwdata[7:0];
				papd_pkg::IDX_PPC:  n.ppc = pwdata[1:0];
				papd_pkg::IDX_DATA: begin
					n.wdata  = pwdata[7:0];
					n.wr_stb = 1'b1;
				end
				default: ;
			endcase
		end
		if (rd && (idx == papd_pkg::IDX_DATA))
			n.rd_stb = 1'b1;

		// Software reset also drops a rate-select powerdown
		if (sw_rst)
			n.dsr[papd_pkg::DSR_PD] = 1'b0;
		n.sw_rst = sw_rst || !n.doc[papd_pkg::DOC_RSTN];

		// Read data caught in the setup phase from live status
		if (psel && !penable) begin
			case (idx)
				papd_pkg::IDX_STA:  n.rdata = {24'h0, fdc_sta};
				papd_pkg::IDX_STB:  n.rdata = {24'h0, fdc_stb};
				papd_pkg::IDX_DOC:  n.rdata = {24'h0, r.doc};
				papd_pkg::IDX_RATE: n.rdata = {24'h0, fdc_msr};
				papd_pkg::IDX_DATA: n.rdata = {24'h0, fdc_data_rd};
				papd_pkg::IDX_DIN:  n.rdata = {24'h0, fdc_din};
				papd_pkg::IDX_DPD:  n.rdata = {24'h0, r.dpd};
				papd_pkg::IDX_APD:  n.rdata = {24'h0, r.apd};
				papd_pkg::IDX_PST:  n.rdata = {24'h0, r.ecp_pd, r.epp_pd,
					u_rx_pd, u_tx_pd, tmr_done, r.pd};
				papd_pkg::IDX_PPC:  n.rdata = {30'h0, r.ppc};
				default:            n.rdata = 32'h0;
			endcase
		end

		// Floppy power state
		case (r.st)
			papd_pkg::FD_RUN: begin
				if (n.dsr[papd_pkg::DSR_PD])
					n.st = papd_pkg::FD_RATE_PD;
				else if (fd_idle && !wake)
					n.st = papd_pkg::FD_AUTO_PD;
			end
			papd_pkg::FD_AUTO_PD: begin
				if (n.dsr[papd_pkg::DSR_PD])
					n.st = papd_pkg::FD_RATE_PD;
				else if (!fd_auto_en || wake)
					n.st = papd_pkg::FD_RUN;
			end
			papd_pkg::FD_RATE_PD: begin
				// Back to run; auto powerdown then decides again
				if (!n.dsr[papd_pkg::DSR_PD])
					n.st = papd_pkg::FD_RUN;
			end
			default: n.st = papd_pkg::FD_RUN;
		endcase
		n.pd = (n.st != papd_pkg::FD_RUN) || n.dpd[papd_pkg::CFG_FD];

		// Drive pins; tristated ones get their enables from pd
		n.mtr_n  = ~n.doc[papd_pkg::DOC_MTR+1:papd_pkg::DOC_MTR];
		n.ds_n   = {~n.doc[0], n.doc[0]};
		n.wd_n   = core_wdata_n;
		n.wg_n   = core_wgate_n;
		n.dir_n  = core_dir_n;
		n.step_n = core_step_n;
		n.hd_n   = core_hdsel_n;
		n.den    = core_den;

		// Parallel port logic follows mode changes every cycle
		n.epp_pd = r.dpd[papd_pkg::CFG_PP] || (r.apd[papd_pkg::CFG_PP]
			&& (!r.ppc[0] || (r.ppc[1] && (ecr_mode != papd_pkg::ECR_EPP))));
		n.ecp_pd = r.dpd[papd_pkg::CFG_PP] || (r.apd[papd_pkg::CFG_PP]
			&& (!r.ppc[1] || (ecr_mode == papd_pkg::ECR_SPP)
			|| (ecr_mode == papd_pkg::ECR_PS2)
			|| (ecr_mode == papd_pkg::ECR_EPP)));
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r       <= '0;
			r.st    <= papd_pkg::FD_RUN;
			r.doc   <= papd_pkg::DOC_RST;
			r.dsr   <= papd_pkg::DSR_RST;
			r.rate_control_write   <= papd_pkg::CCR_RST;
			r.dpd   <= papd_pkg::CFG_RST;
			r.apd   <= papd_pkg::CFG_RST;
			r.mtr_n <= 2'h3;
			r.ds_n  <= 2'h3;
			r.wd_n  <= 1'b1;
			r.wg_n  <= 1'b1;
			r.dir_n <= 1'b1;
			r.step_n <= 1'b1;
			r.hd_n  <= 1'b1;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign prdata          = r.rdata;
	assign fdc_data_wr     = r.wdata;
	assign fdc_data_wr_stb = r.wr_stb;
	assign fdc_data_rd_stb = r.rd_stb;
	assign fdc_soft_reset  = r.sw_rst;
	assign fdc_rate        = r.dsr;
	assign fdc_ccr         = r.rate_control_write;
	assign fdc_pd          = r.pd;

	// Drive inputs are never turned around; only outputs are released
	assign motor_on_out_n       = r.mtr_n;
	assign motor_on_oe          = !r.pd;
	assign drive_select_out_n   = r.ds_n;
	assign drive_select_oe      = !r.pd;
	assign write_data_out_n     = r.wd_n;
	assign write_data_oe        = !r.pd;
	assign write_gate_out_n     = r.wg_n;
	assign write_gate_oe        = !r.pd;
	assign step_direction_out_n = r.dir_n;
	assign step_pulse_out_n     = r.step_n;
	assign head_select_out_n    = r.hd_n;
	assign drive_density_out    = r.den;

	assign uart_tx_pd     = u_tx_pd;
	assign uart_rx_pd     = u_rx_pd;
	assign uart_ri_change = u_ri_chg;
	assign epp_pd         = r.epp_pd;
	assign ecp_pd         = r.ecp_pd;
endmodule

/* File: hw/papd_uart_if.sv */
`timescale 1ns/1ns
interface papd_uart_if;
	logic thr_empty;
	logic tsr_empty;
	logic rx_fifo_empty;
	logic rx_idle;
	logic rxd;
	logic ri;
	logic thb_wr;
	logic auto_en;
	logic direct_pd;
	logic tx_pd;
	logic rx_pd;
	logic ri_change;
	modport ctl (input thr_empty, tsr_empty, rx_fifo_empty, rx_idle, rxd, ri, thb_wr,
		auto_en, direct_pd, output tx_pd, rx_pd, ri_change);
	modport top (output thr_empty, tsr_empty, rx_fifo_empty, rx_idle, rxd, ri, thb_wr,
		auto_en, direct_pd, input tx_pd, rx_pd, ri_change);
endinterface

/* File: hw/papd_uart_pd.sv */
`timescale 1ns/1ns
module papd_uart_pd (
	input  wire logic pclk,
	input  wire logic presetn,
	papd_uart_if.ctl  u
);
	typedef struct packed {
		logic tx_apd;
		logic rx_apd;
		logic rx_hold;
		logic rxd_q;
		logic ri_q;
		logic ri_chg;
		logic tx_pd;
		logic rx_pd;
	} papd_uart_st_t;
	papd_uart_st_t r;
	papd_uart_st_t n;

	// Transmit and receive halves sleep independently
	always_comb begin
		n        = r;
		n.rxd_q  = u.rxd;
		n.ri_q   = u.ri;
		n.ri_chg = (u.ri != r.ri_q);
		if (!u.auto_en || u.thb_wr)
			n.tx_apd = 1'b0;
		else if (u.thr_empty && u.tsr_empty)
			n.tx_apd = 1'b1;
		// Hold awake after a wake until the start bit moves it out of idle
		if (!u.rx_idle)
			n.rx_hold = 1'b0;
		if (!u.auto_en) begin
			n.rx_apd = 1'b0;
		end else if (u.rxd != r.rxd_q) begin
			n.rx_apd  = 1'b0;
			n.rx_hold = 1'b1;
		end else if (u.rx_fifo_empty && u.rx_idle && !r.rx_hold) begin
			n.rx_apd = 1'b1;
		end
		n.tx_pd = n.tx_apd || u.direct_pd;
		n.rx_pd = n.rx_apd || u.direct_pd;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r       <= '0;
			r.rxd_q <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign u.tx_pd     = r.tx_pd;
	assign u.rx_pd     = r.rx_pd;
	assign u.ri_change = r.ri_chg;
endmodule
